// file: rtl/cdrs_pkg.sv
// constants, field layouts and operation codes of the dedicated register set
package cdrs_pkg;
   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [15:0] CDRS_FC_RESET = 16'hFFFD; // mode byte read address
   localparam logic [15:0] CDRS_WORD_RESET = 16'h0000; // acc, temp, pointers
   localparam logic [15:0] CDRS_PSW_RESET = 16'h0030; // bank 0, window 0, level bits set
   // ------------------------------------------------------------------
   // start-up fetch addresses and values
   // ------------------------------------------------------------------
   localparam logic [15:0] CDRS_MODE_ADDR = 16'hFFFD;
   localparam logic [15:0] CDRS_VEC_HI_ADDR = 16'hFFFE;
   localparam logic [15:0] CDRS_VEC_LO_ADDR = 16'hFFFF;
   localparam logic [7:0] CDRS_MODE_SINGLE = 8'h00;
   // ------------------------------------------------------------------
   // processor status word fields and mirror
   // ------------------------------------------------------------------
   localparam int CDRS_BANK_MSB = 15;
   localparam int CDRS_BANK_LSB = 11;
   localparam int CDRS_WIN_MSB = 10;
   localparam int CDRS_WIN_LSB = 8;
   localparam int CDRS_FLAG_MSB = 7;
   localparam logic [15:0] CDRS_MIRROR_ADDR = 16'h0078;
   // ------------------------------------------------------------------
   // address map of the internal areas
   // ------------------------------------------------------------------
   localparam logic [7:0] CDRS_GPR_BASE_HI = 8'h01; // banks sit at 0x0100..0x01FF
   localparam logic [15:0] CDRS_STACK_STEP = 16'h0002;
   localparam logic [15:0] CDRS_RAM_TOP = 16'h047F; // highest internal RAM address
   localparam logic [15:0] CDRS_FLASH_BASE = 16'h8000; // start of flash
   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      CDRS_OP_NOP = 4'b0000,
      CDRS_OP_MOV_A_W = 4'b0001, // word move into acc, old acc to temp
      CDRS_OP_MOV_A_B = 4'b0010, // byte move into acc, old low byte to temp
      CDRS_OP_ALU_A_W = 4'b0011, // word result into acc
      CDRS_OP_ALU_A_B = 4'b0100, // byte result into acc low byte
      CDRS_OP_WR_TEMP = 4'b0101,
      CDRS_OP_WR_IX = 4'b0110,
      CDRS_OP_WR_EP = 4'b0111,
      CDRS_OP_WR_SP = 4'b1000,
      CDRS_OP_PUSH = 4'b1001,
      CDRS_OP_POP = 4'b1010,
      CDRS_OP_PS_FROM_A = 4'b1011,
      CDRS_OP_A_FROM_PS = 4'b1100,
      CDRS_OP_FC_LOAD = 4'b1101,
      CDRS_OP_FC_STEP = 4'b1110
   } cdrs_op_t;
   typedef enum logic [2:0] {
      CDRS_ST_IDLE = 3'b000,
      CDRS_ST_MODE = 3'b001,
      CDRS_ST_VEC_HI = 3'b010,
      CDRS_ST_VEC_LO = 3'b011,
      CDRS_ST_RUN = 3'b100
   } cdrs_state_t;
endpackage

// file: rtl/cdrs_addr_calc.sv
// effective address forming for direct, indexed and bank register access
`timescale 1ns/1ps
module cdrs_addr_calc (
   input wire logic [15:0] index_pointer,
   input wire logic [7:0] index_offset,
   input wire logic [2:0] direct_window,
   input wire logic [7:0] direct_operand,
   input wire logic [4:0] bank_select,
   input wire logic [2:0] reg_num,
   output logic [15:0] indexed_addr,
   output logic [15:0] direct_addr,
   output logic [15:0] gpr_addr
);
   // ------------------------------------------------------------------
   // address arithmetic
   // ------------------------------------------------------------------
   // signed offset, -128..+127, wraps in the 16-bit space
   assign indexed_addr = index_pointer + {{8{index_offset[7]}}, index_offset};
   // low half maps through; upper half lands in window n at 0x80*(n+1)
   always_comb begin
      if (!direct_operand[7]) begin
         direct_addr = {8'h00, direct_operand};
      end else begin
         direct_addr = {5'b0_0000, 4'(direct_window) + 4'h1, direct_operand[6:0]};
      end
   end
   // bank n register r at 0x0100 + 8n + r, never above 0x01FF
   assign gpr_addr = {cdrs_pkg::CDRS_GPR_BASE_HI, bank_select, reg_num};
endmodule // cdrs_addr_calc

// file: rtl/cdrs_startup_seq.sv
// reset-release sequencer: mode byte fetch, vector fetch, then run
`timescale 1ns/1ps
module cdrs_startup_seq (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   output logic mem_rd_req,
   output logic [15:0] mem_addr,
   output logic fc_load,
   output logic [15:0] fc_value,
   output logic running,
   output logic mode_fault
);
   cdrs_pkg::cdrs_state_t state_r, state_nxt;
   logic [7:0] vec_hi_r, vec_hi_nxt;
   logic mode_fault_r, mode_fault_nxt;

   // ------------------------------------------------------------------
   // sequence: one byte read per fetch state, advancing on each acknowledge
   // ------------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      vec_hi_nxt = vec_hi_r;
      mode_fault_nxt = mode_fault_r;
      fc_load = 1'b0;
      fc_value = {vec_hi_r, mem_rdata};
      mem_rd_req = 1'b0;
      mem_addr = cdrs_pkg::CDRS_MODE_ADDR;
      case (state_r)
         cdrs_pkg::CDRS_ST_IDLE: begin
            state_nxt = cdrs_pkg::CDRS_ST_MODE;
         end
         cdrs_pkg::CDRS_ST_MODE: begin
            mem_rd_req = 1'b1;
            if (mem_ack) begin
               // anything but the single-chip value is reported, never obeyed
               mode_fault_nxt = (mem_rdata != cdrs_pkg::CDRS_MODE_SINGLE);
               state_nxt = cdrs_pkg::CDRS_ST_VEC_HI;
            end
         end
         cdrs_pkg::CDRS_ST_VEC_HI: begin
            mem_rd_req = 1'b1;
            mem_addr = cdrs_pkg::CDRS_VEC_HI_ADDR;
            if (mem_ack) begin
               vec_hi_nxt = mem_rdata;
               state_nxt = cdrs_pkg::CDRS_ST_VEC_LO;
            end
         end
         cdrs_pkg::CDRS_ST_VEC_LO: begin
            mem_rd_req = 1'b1;
            mem_addr = cdrs_pkg::CDRS_VEC_LO_ADDR;
            if (mem_ack) begin
               fc_load = 1'b1;
               state_nxt = cdrs_pkg::CDRS_ST_RUN;
            end
         end
         default: begin
            state_nxt = cdrs_pkg::CDRS_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= cdrs_pkg::CDRS_ST_IDLE;
         vec_hi_r <= 8'h00;
         mode_fault_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         vec_hi_r <= vec_hi_nxt;
         mode_fault_r <= mode_fault_nxt;
      end
   end

   assign running = (state_r == cdrs_pkg::CDRS_ST_RUN);
   assign mode_fault = mode_fault_r;
endmodule // cdrs_startup_seq

// file: rtl/cdrs_register_set.sv
// dedicated register set of the 8-bit core with its start-up fetch
// ----------------------------------------------------------------------
// Overview of operation
// - only internal RAM and flash, no external bus
// - mode byte read from flash 0xFFFD
// - reset: mode byte, then vector, then execute
// - seven 16-bit registers; accumulators byte-usable
// - fetch counter updates; reset value 0xFFFD
// - accumulators and pointers reset to zero
// - byte ops on acc keep upper byte
// - byte ops use temp low byte only
// - move into acc copies old acc to temp
// - index pointer plus signed byte offset
// - stack pointer addresses last pushed item
// - bank select bits 15:11, flags 7:0
// - direct window bits 10:8 selects direct region
// - status word as a whole only via word moves with acc
// - bank and window mirrored at 0x0078
// - 32 banks of eight byte registers
// - banks lie within 0x0100..0x01FF
// - bank select resets to zero
// - direct 0x00..0x7F map straight through
// - window resets to 0; each value own window
// ----------------------------------------------------------------------
`timescale 1ns/1ps
module cdrs_register_set (
   input wire logic sys_clk,
   input wire logic reset_n,
   // execution side
   input wire logic op_valid,
   input wire cdrs_pkg::cdrs_op_t op_code,
   input wire logic [15:0] op_data,
   input wire logic flag_we,
   input wire logic [7:0] flag_in,
   input wire logic [7:0] index_offset,
   input wire logic [7:0] direct_operand,
   input wire logic [2:0] reg_num,
   // data bus snoop for the mirror byte
   input wire logic dbus_rd,
   input wire logic dbus_wr,
   input wire logic [15:0] dbus_addr,
   input wire logic [7:0] dbus_wdata,
   output logic dbus_hit,
   output logic [7:0] dbus_rdata,
   // internal memory port used by the start-up fetch
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   output logic mem_rd_req,
   output logic [15:0] mem_addr,
   output logic ext_bus_req,
   // register values and derived addresses
   output logic [15:0] fetch_counter,
   output logic [15:0] acc_word,
   output logic [7:0] acc_lower,
   output logic [7:0] acc_upper,
   output logic [15:0] temp_word,
   output logic [7:0] temp_lower,
   output logic [15:0] index_pointer,
   output logic [15:0] extra_pointer,
   output logic [15:0] stack_top,
   output logic [15:0] processor_status_word,
   output logic [4:0] bank_select,
   output logic [2:0] direct_window,
   output logic [7:0] flag_byte,
   output logic [15:0] indexed_addr,
   output logic [15:0] direct_addr,
   output logic [15:0] gpr_addr,
   output logic core_running,
   output logic mode_fault
);
   logic [15:0] fc_r, fc_nxt;
   logic [15:0] acc_r, acc_nxt;
   logic [15:0] temp_r, temp_nxt;
   logic [15:0] ix_r, ix_nxt;
   logic [15:0] ep_r, ep_nxt;
   logic [15:0] sp_r, sp_nxt;
   logic [15:0] psw_r, psw_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic hit_r, hit_nxt;
   logic fc_load;
   logic [15:0] fc_value;
   logic op_go;
   logic mirror_wr;
   logic mirror_rd;

   // ------------------------------------------------------------------
   // start-up sequencer and address forming
   // ------------------------------------------------------------------
   cdrs_startup_seq u_startup (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata),
      .mem_rd_req(mem_rd_req),
      .mem_addr(mem_addr),
      .fc_load(fc_load),
      .fc_value(fc_value),
      .running(core_running),
      .mode_fault(mode_fault)
   );

   cdrs_addr_calc u_addr (
      .index_pointer(ix_r),
      .index_offset(index_offset),
      .direct_window(psw_r[cdrs_pkg::CDRS_WIN_MSB:cdrs_pkg::CDRS_WIN_LSB]),
      .direct_operand(direct_operand),
      .bank_select(psw_r[cdrs_pkg::CDRS_BANK_MSB:cdrs_pkg::CDRS_BANK_LSB]),
      .reg_num(reg_num),
      .indexed_addr(indexed_addr),
      .direct_addr(direct_addr),
      .gpr_addr(gpr_addr)
   );

   // single-chip only: there is no external bus to request
   assign ext_bus_req = 1'b0;
   // operations are ignored until the start-up fetch has finished
   assign op_go = op_valid && core_running;
   assign mirror_wr = dbus_wr && (dbus_addr == cdrs_pkg::CDRS_MIRROR_ADDR);
   assign mirror_rd = dbus_rd && (dbus_addr == cdrs_pkg::CDRS_MIRROR_ADDR);

   // ------------------------------------------------------------------
   // next values of the dedicated registers
   // ------------------------------------------------------------------
   always_comb begin
      fc_nxt = fc_r;
      acc_nxt = acc_r;
      temp_nxt = temp_r;
      ix_nxt = ix_r;
      ep_nxt = ep_r;
      sp_nxt = sp_r;
      psw_nxt = psw_r;
      if (fc_load) begin
         fc_nxt = fc_value;
      end
      // the mirror write lands at the edge, so the next instruction sees it
      if (mirror_wr) begin
         psw_nxt[15:8] = dbus_wdata;
      end
      if (flag_we && core_running) begin
         psw_nxt[cdrs_pkg::CDRS_FLAG_MSB:0] = flag_in;
      end
      if (op_go) begin
         case (op_code)
            cdrs_pkg::CDRS_OP_MOV_A_W: begin
               temp_nxt = acc_r;
               acc_nxt = op_data;
            end
            cdrs_pkg::CDRS_OP_MOV_A_B: begin
               temp_nxt = {temp_r[15:8], acc_r[7:0]};
               acc_nxt = {acc_r[15:8], op_data[7:0]};
            end
            cdrs_pkg::CDRS_OP_ALU_A_W: begin
               acc_nxt = op_data;
            end
            cdrs_pkg::CDRS_OP_ALU_A_B: begin
               acc_nxt = {acc_r[15:8], op_data[7:0]};
            end
            cdrs_pkg::CDRS_OP_WR_TEMP: begin
               temp_nxt = op_data;
            end
            cdrs_pkg::CDRS_OP_WR_IX: begin
               ix_nxt = op_data;
            end
            cdrs_pkg::CDRS_OP_WR_EP: begin
               ep_nxt = op_data;
            end
            cdrs_pkg::CDRS_OP_WR_SP: begin
               sp_nxt = op_data;
            end
            cdrs_pkg::CDRS_OP_PUSH: begin
               // pre-decrement keeps the pointer on the newest item
               sp_nxt = sp_r - cdrs_pkg::CDRS_STACK_STEP;
            end
            cdrs_pkg::CDRS_OP_POP: begin
               sp_nxt = sp_r + cdrs_pkg::CDRS_STACK_STEP;
            end
            cdrs_pkg::CDRS_OP_PS_FROM_A: begin
               // a word move overrides a same-cycle mirror or flag write
               psw_nxt = acc_r;
            end
            cdrs_pkg::CDRS_OP_A_FROM_PS: begin
               temp_nxt = acc_r;
               acc_nxt = psw_r;
            end
            cdrs_pkg::CDRS_OP_FC_LOAD: begin
               fc_nxt = op_data;
            end
            cdrs_pkg::CDRS_OP_FC_STEP: begin
               fc_nxt = fc_r + op_data;
            end
            default: begin
               fc_nxt = fc_nxt;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fc_r <= cdrs_pkg::CDRS_FC_RESET;
         acc_r <= cdrs_pkg::CDRS_WORD_RESET;
         temp_r <= cdrs_pkg::CDRS_WORD_RESET;
         ix_r <= cdrs_pkg::CDRS_WORD_RESET;
         ep_r <= cdrs_pkg::CDRS_WORD_RESET;
         sp_r <= cdrs_pkg::CDRS_WORD_RESET;
         psw_r <= cdrs_pkg::CDRS_PSW_RESET;
      end else begin
         fc_r <= fc_nxt;
         acc_r <= acc_nxt;
         temp_r <= temp_nxt;
         ix_r <= ix_nxt;
         ep_r <= ep_nxt;
         sp_r <= sp_nxt;
         psw_r <= psw_nxt;
      end
   end

   // ------------------------------------------------------------------
   // mirror read: registered answer one cycle after the read strobe
   // ------------------------------------------------------------------
   always_comb begin
      hit_nxt = mirror_rd;
      rdata_nxt = mirror_rd ? psw_r[15:8] : 8'h00;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         hit_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         hit_r <= hit_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs, all straight from registers
   // ------------------------------------------------------------------
   assign dbus_hit = hit_r;
   assign dbus_rdata = rdata_r;
   assign fetch_counter = fc_r;
   assign acc_word = acc_r;
   assign acc_lower = acc_r[7:0];
   assign acc_upper = acc_r[15:8];
   assign temp_word = temp_r;
   assign temp_lower = temp_r[7:0];
   assign index_pointer = ix_r;
   assign extra_pointer = ep_r;
   assign stack_top = sp_r;
   assign processor_status_word = psw_r;
   assign bank_select = psw_r[cdrs_pkg::CDRS_BANK_MSB:cdrs_pkg::CDRS_BANK_LSB];
   assign direct_window = psw_r[cdrs_pkg::CDRS_WIN_MSB:cdrs_pkg::CDRS_WIN_LSB];
   assign flag_byte = psw_r[cdrs_pkg::CDRS_FLAG_MSB:0];

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   no_ext_bus_a: assert property (ext_bus_req == 1'b0)
      else $error("external bus requested");
   mode_first_a: assert property ($rose(mem_rd_req) |-> mem_addr == 16'hFFFD)
      else $error("start-up did not begin with the mode byte");
   startup_order_a: assert property (
      (mem_rd_req && mem_ack && mem_addr == 16'hFFFD)
         |=> (mem_addr == 16'hFFFE && mem_rd_req))
      else $error("vector fetch did not follow mode byte");
   vector_load_a: assert property (
      (mem_rd_req && mem_ack && mem_addr == 16'hFFFF)
         |=> (core_running && fetch_counter[7:0] == $past(mem_rdata)))
      else $error("fetch counter not loaded from vector");
   byte_keeps_upper_a: assert property (
      (op_go && op_code == cdrs_pkg::CDRS_OP_ALU_A_B)
         |=> (acc_upper == $past(acc_upper) && acc_lower == $past(op_data[7:0])))
      else $error("byte op changed acc upper byte");
   move_to_temp_a: assert property (
      (op_go && op_code == cdrs_pkg::CDRS_OP_MOV_A_W && !fc_load)
         |=> temp_word == $past(acc_word))
      else $error("old acc not copied to temp");
   byte_move_temp_a: assert property (
      (op_go && op_code == cdrs_pkg::CDRS_OP_MOV_A_B)
         |=> (temp_word[15:8] == $past(temp_word[15:8])
              && temp_lower == $past(acc_lower)))
      else $error("byte move disturbed temp upper byte");
   // distance from the pointer must be the offset itself and stay within -128..+127
   indexed_sum_a: assert property (
      8'(indexed_addr - index_pointer) == index_offset
         && 16'(indexed_addr - index_pointer + 16'h0080) < 16'h0100)
      else $error("indexed address wrong");
   push_step_a: assert property (
      (op_go && op_code == cdrs_pkg::CDRS_OP_PUSH) |=> stack_top == $past(stack_top) - 16'h0002)
      else $error("push did not lower stack pointer by two");
   mirror_now_a: assert property (
      (mirror_wr && !(op_go && op_code == cdrs_pkg::CDRS_OP_PS_FROM_A))
         |=> (bank_select == $past(dbus_wdata[7:3]) && direct_window == $past(dbus_wdata[2:0])))
      else $error("mirror write not visible next cycle");
   mirror_read_a: assert property (
      mirror_rd |=> (dbus_hit && dbus_rdata == $past(psw_r[15:8])))
      else $error("mirror read returned wrong byte");
   direct_map_a: assert property (
      (!direct_operand[7] |-> direct_addr == {8'h00, direct_operand})
         and (direct_operand[7] |-> direct_addr <= cdrs_pkg::CDRS_RAM_TOP))
      else $error("direct address out of map");
   // arithmetic form of the bank map, independent of the concatenation above
   gpr_range_a: assert property (
      gpr_addr == 16'h0100 + 16'(bank_select) * 16'h0008 + 16'(reg_num)
         && gpr_addr <= 16'h01FF)
      else $error("bank register address outside its area");

   startup_done_c: cover property ($rose(core_running));
   mode_fault_c: cover property ($rose(mode_fault));
   mirror_write_c: cover property (mirror_wr ##1 mirror_rd);
   move_chain_c: cover property ((op_go && op_code == cdrs_pkg::CDRS_OP_MOV_A_W) ##1
      (op_go && op_code == cdrs_pkg::CDRS_OP_MOV_A_B));
endmodule // cdrs_register_set

// file: bench/cdrs_mem_model.sv
// internal flash and ram model answering the start-up fetch of the register set
`timescale 1ns/1ps
module cdrs_mem_model #(
   parameter logic [15:0] VECTOR = 16'h9ABC
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic mem_rd_req,
   input wire logic [15:0] mem_addr,
   input wire logic [3:0] wait_cycles,
   input wire logic [7:0] mode_byte,
   output logic mem_ack,
   output logic [7:0] mem_rdata
);
   logic [3:0] cnt_r;
   logic [7:0] last_r;
   // answer after the chosen wait; an idle bus shows the inverse of the last byte
   always_comb begin
      mem_ack = mem_rd_req && (cnt_r == wait_cycles);
      mem_rdata = ~last_r;
      if (mem_ack) begin
         case (mem_addr)
            cdrs_pkg::CDRS_MODE_ADDR: mem_rdata = mode_byte;
            cdrs_pkg::CDRS_VEC_HI_ADDR: mem_rdata = VECTOR[15:8];
            cdrs_pkg::CDRS_VEC_LO_ADDR: mem_rdata = VECTOR[7:0];
            default: mem_rdata = 8'hA5;
         endcase
      end
   end
   // wait counter restarts on every answer, so back to back reads get the same delay
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 4'h0;
         last_r <= 8'h00;
      end else begin
         cnt_r <= (mem_rd_req && !mem_ack) ? cnt_r + 4'h1 : 4'h0;
         if (mem_ack) last_r <= mem_rdata;
      end
   end
endmodule // cdrs_mem_model

// file: bench/cdrs_register_set_tb.sv
// self-checking testbench of the dedicated register set
`timescale 1ns/1ps
module cdrs_register_set_tb;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic op_valid = 1'b0, flag_we = 1'b0, dbus_rd = 1'b0, dbus_wr = 1'b0;
   cdrs_pkg::cdrs_op_t op_code = cdrs_pkg::CDRS_OP_NOP;
   logic [15:0] op_data = 16'h0000, dbus_addr = 16'h0000;
   logic [7:0] flag_in = 8'h00, index_offset = 8'h00, direct_operand = 8'h00;
   logic [7:0] dbus_wdata = 8'h00, mode_byte = 8'h00;
   logic [2:0] reg_num = 3'h0, direct_window;
   logic [3:0] wait_cycles = 4'h0;
   logic [7:0] mem_rdata, dbus_rdata, acc_lower, acc_upper, temp_lower, flag_byte;
   logic [4:0] bank_select;
   logic mem_ack, dbus_hit, mem_rd_req, ext_bus_req, core_running, mode_fault;
   logic [15:0] mem_addr, fetch_counter, acc_word, temp_word, index_pointer, extra_pointer;
   logic [15:0] stack_top, processor_status_word, indexed_addr, direct_addr, gpr_addr;
   int error_cnt = 0;
   int comparisons = 0;
   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;
   cdrs_register_set u_cdrs_register_set (.sys_clk, .reset_n, .op_valid, .op_code, .op_data,
      .flag_we, .flag_in, .index_offset, .direct_operand, .reg_num, .dbus_rd, .dbus_wr,
      .dbus_addr, .dbus_wdata, .dbus_hit, .dbus_rdata, .mem_ack, .mem_rdata, .mem_rd_req,
      .mem_addr, .ext_bus_req, .fetch_counter, .acc_word, .acc_lower, .acc_upper, .temp_word,
      .temp_lower, .index_pointer, .extra_pointer, .stack_top, .processor_status_word,
      .bank_select, .direct_window, .flag_byte, .indexed_addr, .direct_addr, .gpr_addr,
      .core_running, .mode_fault);
   cdrs_mem_model u_cdrs_mem_model (.sys_clk, .reset_n, .mem_rd_req, .mem_addr, .wait_cycles,
      .mode_byte, .mem_ack, .mem_rdata);
   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one op pulse, then an idle cycle so strobes never toggle twice in one step
   task automatic op(input cdrs_pkg::cdrs_op_t c, input logic [15:0] d);
      op_valid = 1'b1;
      op_code = c;
      op_data = d;
      @(posedge sys_clk) #1;
      op_valid = 1'b0;
      @(posedge sys_clk) #1;
   endtask
   task automatic dwr(input logic [15:0] a, input logic [7:0] d);
      dbus_wr = 1'b1;
      dbus_addr = a;
      dbus_wdata = d;
      @(posedge sys_clk) #1;
      dbus_wr = 1'b0;
      @(posedge sys_clk) #1;
   endtask
   // hit and data stand only in the cycle after the strobe
   task automatic drd(input logic [15:0] a, input logic h, input logic [7:0] d);
      dbus_rd = 1'b1;
      dbus_addr = a;
      @(posedge sys_clk) #1;
      dbus_rd = 1'b0;
      chk("mirror hit", dbus_hit, h);
      chk("mirror data", dbus_rdata, d);
      @(posedge sys_clk) #1;
   endtask
   task automatic end_of_test();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   // reset, then start-up fetch with an op held up the whole time that must be dropped
   task automatic startup(input logic [3:0] w, input logic [7:0] mb);
      logic [15:0] seen [$];
      wait_cycles = w;
      mode_byte = mb;
      reset_n = 1'b0;
      op_valid = 1'b1;
      op_code = cdrs_pkg::CDRS_OP_MOV_A_W;
      op_data = 16'hFFFF;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("fc reset", fetch_counter, cdrs_pkg::CDRS_FC_RESET);
      chk("word reset", acc_word | temp_word | index_pointer | extra_pointer | stack_top,
         16'h0000);
      chk("psw reset", processor_status_word, cdrs_pkg::CDRS_PSW_RESET);
      chk("req in reset", mem_rd_req, 1'b0);
      reset_n = 1'b1;
      for (int i = 0; i < 80 && core_running !== 1'b1; i++) begin
         @(posedge sys_clk) #1;
         if (mem_rd_req === 1'b1 && mem_ack === 1'b1) seen.push_back(mem_addr);
         chk("ext bus", ext_bus_req, 1'b0);
      end
      op_valid = 1'b0;
      chk("running", core_running, 1'b1);
      chk("fetch count", 16'(seen.size()), 16'h0003);
      for (int i = 0; i < 3; i++) chk("fetch addr", seen[i], 16'hFFFD + 16'(i));
      chk("vector", fetch_counter, 16'h9ABC);
      chk("dropped op", acc_word, 16'h0000);
      chk("mode fault", mode_fault, mb != 8'h00);
      @(posedge sys_clk) #1;
   endtask
   task automatic t_moves();
      op(cdrs_pkg::CDRS_OP_MOV_A_W, 16'h1234);
      op(cdrs_pkg::CDRS_OP_MOV_A_W, 16'hABCD);
      chk("temp word", temp_word, 16'h1234);
      op(cdrs_pkg::CDRS_OP_MOV_A_B, 16'hFF56);
      chk("acc byte", acc_word, 16'hAB56);
      chk("acc lower", acc_lower, 16'h0056);
      chk("acc upper", acc_upper, 16'h00AB);
      chk("temp byte", temp_word, 16'h12CD);
      op(cdrs_pkg::CDRS_OP_ALU_A_B, 16'h0077);
      chk("alu byte", acc_word, 16'hAB77);
      chk("temp lower", temp_lower, 16'h00CD);
      op(cdrs_pkg::CDRS_OP_WR_EP, 16'hBEEF);
      chk("extra", extra_pointer, 16'hBEEF);
      // word result into acc must leave temp alone
      op(cdrs_pkg::CDRS_OP_ALU_A_W, 16'h5AA5);
      chk("alu word", acc_word, 16'h5AA5);
      chk("alu keeps temp", temp_word, 16'h12CD);
      op(cdrs_pkg::CDRS_OP_WR_TEMP, 16'h0F0F);
      chk("temp write", temp_word, 16'h0F0F);
   endtask
   task automatic t_addr();
      op(cdrs_pkg::CDRS_OP_WR_IX, 16'h1000);
      index_offset = 8'h80;
      @(posedge sys_clk) #1 chk("index neg", indexed_addr, 16'h0F80);
      index_offset = 8'h7F;
      @(posedge sys_clk) #1 chk("index pos", indexed_addr, 16'h107F);
      dwr(16'h0078, 8'hFD);
      chk("mirror fields", {bank_select, direct_window}, 16'h00FD);
      drd(16'h0078, 1'b1, 8'hFD);
      drd(16'h0079, 1'b0, 8'h00);
      direct_operand = 8'h7F;
      @(posedge sys_clk) #1 chk("direct low", direct_addr, 16'h007F);
      direct_operand = 8'h80;
      reg_num = 3'h7;
      @(posedge sys_clk) #1 chk("direct win5", direct_addr, 16'h0300);
      chk("gpr top", gpr_addr, 16'h01FF);
      dwr(16'h0078, 8'h10);
      direct_operand = 8'h90;
      @(posedge sys_clk) #1 chk("direct win0", direct_addr, 16'h0090);
      chk("gpr bank2", gpr_addr, 16'h0117);
   endtask
   task automatic t_psw();
      op(cdrs_pkg::CDRS_OP_MOV_A_W, 16'hC2A5);
      op(cdrs_pkg::CDRS_OP_PS_FROM_A, 16'h0000);
      chk("psw", processor_status_word, 16'hC2A5);
      chk("fields", {bank_select, direct_window, flag_byte}, 16'hC2A5);
      flag_we = 1'b1;
      flag_in = 8'h3C;
      @(posedge sys_clk) #1;
      flag_we = 1'b0;
      op(cdrs_pkg::CDRS_OP_A_FROM_PS, 16'h0000);
      chk("acc from psw", acc_word, 16'hC23C);
      chk("temp from psw", temp_word, 16'hC2A5);
   endtask
   task automatic t_stack();
      op(cdrs_pkg::CDRS_OP_WR_SP, 16'h0200);
      op(cdrs_pkg::CDRS_OP_PUSH, 16'h0000);
      chk("push", stack_top, 16'h01FE);
      op(cdrs_pkg::CDRS_OP_POP, 16'h0000);
      chk("pop", stack_top, 16'h0200);
      op(cdrs_pkg::CDRS_OP_FC_LOAD, 16'h8100);
      op(cdrs_pkg::CDRS_OP_FC_STEP, 16'h0003);
      chk("fc step", fetch_counter, 16'h8103);
   endtask
   // ------------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      startup(4'h0, 8'h00);
      t_moves();
      t_addr();
      t_psw();
      t_stack();
      // second reset in mid-run with slow answers and a wrong mode byte
      startup(4'h3, 8'h01);
      end_of_test();
   end
   initial begin
      #100000;
      error_cnt++;
      end_of_test();
   end
endmodule // cdrs_register_set_tb
